/* design/sleep_and_module_clock_gating.sv */
// Sleep mode sequencing and per-peripheral clock gating controller
//
// Function
// - Select 000 gives idle: only cpu and flash clocks stop.
// - After an interrupt wake, hold the processor four cycles beyond start-up.
// - Select 001 gives noise reduction: io, cpu, flash stop; converter, pll, oscillator run.
// - Entering noise reduction with converter enabled starts a conversion automatically.
// - Noise reduction wakes on conversion done, resets, timer, nonvolatile ready, level lines.
// - Select 010 gives power-down: oscillator and all generated clocks stop.
// - Power-down wakes only on resets, stage controller interrupt, level lines.
// - Power-down wake waits the fuse-selected restart delay.
// - Select 110 with crystal gives standby: power-down but oscillator keeps running.
// - Standby resumes six cycles after a valid wake.
// - A set gate bit freezes the peripheral and blocks its register access.
// - Clearing a gate bit restarts the clock; peripheral resumes its frozen state.
// - Per-module gating matters only in active and idle modes, and for the converter (bit 0) in noise reduction too.
// - Bits 7,6,5 stop stage controllers 2,1,0.
// - Bits 4,3 stop timer 1 and timer 0.
// - Bit 2 stops the serial peripheral, bit 1 the serial port.
// - Bit 0 stops the converter clock; comparator loses the converter multiplexer.
// - An enabled converter stays enabled in sleep; re-enable makes next conversion extended.
// - Power-down and standby disable the comparator unless it uses the internal reference.
// - With io and converter clocks stopped, input buffers are disabled except wake inputs.
// - Enabled watchdog and brown-out detector keep running in every sleep mode.
// - With the debug fuse set, the main oscillator runs in every sleep mode.
//
// Local design decisions: the strobed register port and the placing of the registers.
`timescale 1ns/1ns
`include "sleep_gate_params.svh"

module sleep_and_module_clock_gating #(
	parameter int unsigned PDOWN_WAKE_SHORT = 1024,
	parameter int unsigned PDOWN_WAKE_LONG = 16384
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic sleep_instr,
	input wire sleep_gate_pkg::wake_src_s wake_src,
	input wire logic [3:0] external_interrupt_lines,
	input wire logic [3:0] clock_source_fuse,
	input wire logic debug_enable_fuse,
	input wire logic converter_enable,
	input wire logic comparator_enable,
	input wire logic comparator_uses_ref,
	input wire logic watchdog_enable,
	input wire logic brownout_enable,
	output sleep_gate_pkg::clk_en_s clk_en,
	output logic [7:0] periph_clk_en,
	output logic [7:0] periph_reg_block,
	output logic cpu_halt,
	output logic conv_start,
	output logic conv_extended,
	output logic conv_keep_enabled,
	output logic comparator_off,
	output logic comparator_mux_block,
	output logic input_buf_disable,
	output logic watchdog_run,
	output logic brownout_run
);
	logic [1:0] rst_sync;
	logic rst_n;
	logic [3:0] ext_meta;
	logic [3:0] ext_sync;

	logic [7:0] sleep_control_register;
	logic [7:0] peripheral_clock_gate;

	sleep_gate_pkg::sleep_state_e state;
	sleep_gate_pkg::sleep_state_e next_state;
	sleep_gate_pkg::sleep_mode_e mode;
	sleep_gate_pkg::sleep_mode_e next_mode;
	sleep_gate_pkg::clk_en_s next_clk_en;
	logic [15:0] count;
	logic [15:0] next_count;
	logic [15:0] restart_cycles;

	logic wake;
	logic level_wake;
	logic xtal_source;
	logic sleep_arm;
	logic [2:0] sleep_mode_select;
	logic conv_en_q;

	assign rst_n = rst_sync[1];
	assign sleep_arm = sleep_control_register[`SLP_ARM_BIT];
	assign sleep_mode_select = sleep_control_register[`SLP_MODE_MSB:`SLP_MODE_LSB];
	assign xtal_source = clock_source_fuse >= `SLP_XTAL_FUSE_MIN;
	// Level lines reach here only once synchronised; a short pulse may be missed
	assign level_wake = |ext_sync;

	// Reset asserts at once but leaves on two edges, so no flop sees a runt release
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			rst_sync <= 2'h0;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end

	// Level lines come from pins, two flops before any logic reads them
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ext_meta <= 4'h0;
			ext_sync <= 4'h0;
		end else begin
			ext_meta <= external_interrupt_lines;
			ext_sync <= ext_meta;
		end
	end

	// Register writes
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sleep_control_register <= `SLP_CTRL_RESET;
		end else if (reg_wr && reg_addr == `SLP_ADDR_SLEEP_CTRL) begin
			sleep_control_register <= {4'h0, reg_wdata[3:0]};
		end
	end

	// Gate bits hold while set; clearing lets the clock back on untouched
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			peripheral_clock_gate <= `SLP_GATE_RESET;
		end else if (reg_wr && reg_addr == `SLP_ADDR_CLOCK_GATE) begin
			peripheral_clock_gate <= reg_wdata;
		end
	end

	// Register reads, data one cycle after the strobe
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				`SLP_ADDR_SLEEP_CTRL: reg_rdata <= sleep_control_register;
				`SLP_ADDR_CLOCK_GATE: reg_rdata <= peripheral_clock_gate;
				`SLP_ADDR_STATUS: reg_rdata <= {state, mode};
				default: reg_rdata <= 8'h00;
			endcase
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// Wake qualification per mode; resets wake through resetn itself
	always_comb begin
		case (mode)
			sleep_gate_pkg::MD_IDLE: wake = wake_src.any_irq | level_wake;
			sleep_gate_pkg::MD_NOISE: wake = wake_src.conv_done | wake_src.timer | wake_src.nvm_ready
				| level_wake;
			sleep_gate_pkg::MD_PDOWN: wake = wake_src.stage_ctrl | level_wake;
			sleep_gate_pkg::MD_STANDBY: wake = wake_src.stage_ctrl | level_wake;
			default: wake = 1'b0;
		endcase
	end

	// Restart delay: fuse picks the power-down delay, standby is fixed
	always_comb begin
		case (mode)
			sleep_gate_pkg::MD_PDOWN: begin
				if (clock_source_fuse[0]) begin
					restart_cycles = 16'(PDOWN_WAKE_LONG);
				end else begin
					restart_cycles = 16'(PDOWN_WAKE_SHORT);
				end
			end
			sleep_gate_pkg::MD_STANDBY: restart_cycles = `SLP_STANDBY_CYCLES;
			default: restart_cycles = 16'h0000;
		endcase
	end

	// Mode decode at the sleep instruction
	always_comb begin
		case (sleep_mode_select)
			`SLP_MODE_IDLE: next_mode = sleep_gate_pkg::MD_IDLE;
			`SLP_MODE_NOISE: next_mode = sleep_gate_pkg::MD_NOISE;
			`SLP_MODE_PDOWN: next_mode = sleep_gate_pkg::MD_PDOWN;
			`SLP_MODE_STANDBY: begin
				if (xtal_source) begin
					next_mode = sleep_gate_pkg::MD_STANDBY;
				end else begin
					next_mode = sleep_gate_pkg::MD_PDOWN;
				end
			end
			default: next_mode = sleep_gate_pkg::MD_IDLE;
		endcase
	end

	// Sequencer
	always_comb begin
		next_state = state;
		next_count = count;
		case (state)
			sleep_gate_pkg::ST_ACTIVE: begin
				if (sleep_instr && sleep_arm) begin
					next_state = sleep_gate_pkg::ST_SLEEP;
				end
			end
			// Counters load one less, so each wait lasts exactly its count
			sleep_gate_pkg::ST_SLEEP: begin
				if (wake) begin
					if (restart_cycles == 16'h0000) begin
						next_state = sleep_gate_pkg::ST_HALT;
						next_count = `SLP_HALT_CYCLES - 16'h0001;
					end else begin
						next_state = sleep_gate_pkg::ST_RESTART;
						next_count = restart_cycles - 16'h0001;
					end
				end
			end
			sleep_gate_pkg::ST_RESTART: begin
				if (count == 16'h0000) begin
					next_state = sleep_gate_pkg::ST_HALT;
					next_count = `SLP_HALT_CYCLES - 16'h0001;
				end else begin
					next_count = count - 16'h0001;
				end
			end
			sleep_gate_pkg::ST_HALT: begin
				if (count == 16'h0000) begin
					next_state = sleep_gate_pkg::ST_ACTIVE;
				end else begin
					next_count = count - 16'h0001;
				end
			end
			default: begin
				next_state = sleep_gate_pkg::ST_ACTIVE;
				next_count = 16'h0000;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= sleep_gate_pkg::ST_ACTIVE;
			count <= 16'h0000;
		end else begin
			state <= next_state;
			count <= next_count;
		end
	end

	// Mode is frozen for the whole sleep; select writes meanwhile apply next time
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			mode <= sleep_gate_pkg::MD_IDLE;
		end else if (state == sleep_gate_pkg::ST_ACTIVE && next_state == sleep_gate_pkg::ST_SLEEP) begin
			mode <= next_mode;
		end
	end

	// Clock domain enables for the coming cycle
	always_comb begin
		next_clk_en = '1;
		case (next_state)
			sleep_gate_pkg::ST_SLEEP: begin
				next_clk_en.cpu = 1'b0;
				next_clk_en.flash = 1'b0;
				case (next_mode_hold())
					sleep_gate_pkg::MD_NOISE: next_clk_en.io = 1'b0;
					sleep_gate_pkg::MD_PDOWN: next_clk_en = '0;
					sleep_gate_pkg::MD_STANDBY: begin
						next_clk_en = '0;
						next_clk_en.main_osc = 1'b1;
					end
					default: next_clk_en.io = 1'b1;
				endcase
			end
			sleep_gate_pkg::ST_RESTART: begin
				// Oscillator settles before anything downstream runs
				next_clk_en = '0;
				next_clk_en.main_osc = 1'b1;
			end
			sleep_gate_pkg::ST_HALT: next_clk_en.cpu = 1'b0;
			default: next_clk_en = '1;
		endcase
		if (debug_enable_fuse) begin
			next_clk_en.main_osc = 1'b1;
		end
	end

	// Mode that applies to the coming cycle
	// Mode only loads on the sleep edge, so the entry cycle needs the decode
	function automatic sleep_gate_pkg::sleep_mode_e next_mode_hold();
		if (state == sleep_gate_pkg::ST_ACTIVE) begin
			return next_mode;
		end
		return mode;
	endfunction : next_mode_hold

	// Enables load with the state, so no domain runs a stale cycle
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			clk_en <= '1;
			cpu_halt <= 1'b0;
		end else begin
			clk_en <= next_clk_en;
			cpu_halt <= next_state != sleep_gate_pkg::ST_ACTIVE;
		end
	end

	// Per-peripheral gating rides on the domain clock, so it only bites in active and idle, plus the converter bit in noise reduction
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			periph_clk_en <= 8'hff;
			periph_reg_block <= 8'h00;
			comparator_mux_block <= 1'b0;
		end else begin
			// All but the converter ride on the io domain
			periph_clk_en[`SLP_GATE_STAGE2] <= next_clk_en.io & ~peripheral_clock_gate[`SLP_GATE_STAGE2];
			periph_clk_en[`SLP_GATE_STAGE1] <= next_clk_en.io & ~peripheral_clock_gate[`SLP_GATE_STAGE1];
			periph_clk_en[`SLP_GATE_STAGE0] <= next_clk_en.io & ~peripheral_clock_gate[`SLP_GATE_STAGE0];
			periph_clk_en[`SLP_GATE_TIMER1] <= next_clk_en.io & ~peripheral_clock_gate[`SLP_GATE_TIMER1];
			periph_clk_en[`SLP_GATE_TIMER0] <= next_clk_en.io & ~peripheral_clock_gate[`SLP_GATE_TIMER0];
			periph_clk_en[`SLP_GATE_SPI] <= next_clk_en.io & ~peripheral_clock_gate[`SLP_GATE_SPI];
			periph_clk_en[`SLP_GATE_SERIAL] <= next_clk_en.io & ~peripheral_clock_gate[`SLP_GATE_SERIAL];
			periph_clk_en[`SLP_GATE_CONV] <= next_clk_en.conv & ~peripheral_clock_gate[`SLP_GATE_CONV];
			periph_reg_block <= peripheral_clock_gate;
			comparator_mux_block <= peripheral_clock_gate[`SLP_GATE_CONV];
		end
	end

	// Converter and comparator side effects
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			conv_en_q <= 1'b0;
			conv_start <= 1'b0;
			conv_extended <= 1'b1;
			conv_keep_enabled <= 1'b0;
		end else begin
			conv_en_q <= converter_enable;
			conv_keep_enabled <= converter_enable;
			conv_start <= state == sleep_gate_pkg::ST_ACTIVE && next_state == sleep_gate_pkg::ST_SLEEP
				&& next_mode == sleep_gate_pkg::MD_NOISE && converter_enable;
			// Set wins over clear, so a re-enable beside a start still marks an extended run
			if (!conv_en_q && converter_enable) begin
				conv_extended <= 1'b1;
			end else if (conv_start) begin
				conv_extended <= 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			comparator_off <= 1'b0;
			input_buf_disable <= 1'b0;
			watchdog_run <= 1'b0;
			brownout_run <= 1'b0;
		end else begin
			comparator_off <= next_state == sleep_gate_pkg::ST_SLEEP && comparator_enable && !comparator_uses_ref
				&& (next_mode_hold() == sleep_gate_pkg::MD_PDOWN
				|| next_mode_hold() == sleep_gate_pkg::MD_STANDBY);
			// External level lines keep their buffers; they are the wake path
			input_buf_disable <= next_state == sleep_gate_pkg::ST_SLEEP && !next_clk_en.io && !next_clk_en.conv;
			// Watchdog and brown-out follow their own enables, never the sleep mode
			watchdog_run <= watchdog_enable;
			brownout_run <= brownout_enable;
		end
	end
endmodule : sleep_and_module_clock_gating

/* design/sleep_gate_params.svh */
// Offsets, field positions, reset values and cycle counts of the sleep controller
`ifndef SLEEP_GATE_PARAMS_SVH
`define SLEEP_GATE_PARAMS_SVH
`define SLP_ADDR_SLEEP_CTRL 4'h0
`define SLP_ADDR_CLOCK_GATE 4'h1
`define SLP_ADDR_STATUS 4'h2
`define SLP_ARM_BIT 0
`define SLP_MODE_LSB 1
`define SLP_MODE_MSB 3
`define SLP_CTRL_RESET 8'h00
`define SLP_GATE_RESET 8'h00
`define SLP_MODE_IDLE 3'h0
`define SLP_MODE_NOISE 3'h1
`define SLP_MODE_PDOWN 3'h2
`define SLP_MODE_STANDBY 3'h6
`define SLP_GATE_STAGE2 7
`define SLP_GATE_STAGE1 6
`define SLP_GATE_STAGE0 5
`define SLP_GATE_TIMER1 4
`define SLP_GATE_TIMER0 3
`define SLP_GATE_SPI 2
`define SLP_GATE_SERIAL 1
`define SLP_GATE_CONV 0
`define SLP_XTAL_FUSE_MIN 4'h8
`define SLP_HALT_CYCLES 16'h0004
`define SLP_STANDBY_CYCLES 16'h0006
`endif

/* design/sleep_gate_pkg.sv */
// Types shared by the sleep and module clock gating controller
package sleep_gate_pkg;
	typedef enum logic [3:0] {
		ST_ACTIVE = 4'b0001,
		ST_SLEEP = 4'b0010,
		ST_RESTART = 4'b0100,
		ST_HALT = 4'b1000
	} sleep_state_e;

	typedef enum logic [3:0] {
		MD_IDLE = 4'b0001,
		MD_NOISE = 4'b0010,
		MD_PDOWN = 4'b0100,
		MD_STANDBY = 4'b1000
	} sleep_mode_e;

	typedef struct packed {
		logic cpu;
		logic flash;
		logic io;
		logic conv;
		logic pll;
		logic main_osc;
	} clk_en_s;

	typedef struct packed {
		logic any_irq;
		logic conv_done;
		logic timer;
		logic nvm_ready;
		logic stage_ctrl;
	} wake_src_s;
endpackage : sleep_gate_pkg

/* dv/wake_source_model.sv */
// Processor-side model: issues sleep instructions and holds wake levels
`timescale 1ns/1ns
module wake_source_model (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic cpu_halt,
	input wire logic sleep_req,
	input wire sleep_gate_pkg::wake_src_s raise,
	output logic sleep_instr,
	output sleep_gate_pkg::wake_src_s wake_src
);
	logic halt_d;
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			halt_d <= 1'h0;
			sleep_instr <= 1'h0;
			wake_src <= '0;
		end else begin
			halt_d <= cpu_halt;
			// A halted core cannot execute the instruction
			sleep_instr <= sleep_req && !cpu_halt;
			// Levels stay until the core runs again, so none is missed
			if (halt_d && !cpu_halt) begin
				wake_src <= '0;
			end else begin
				wake_src <= wake_src | raise;
			end
		end
	end
endmodule : wake_source_model

/* dv/sleep_gate_assertions.sv */
// Concurrent checks on the sleep controller ports
`timescale 1ns/1ns
module sleep_gate_assertions (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [3:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic sleep_instr,
	input wire sleep_gate_pkg::wake_src_s wake_src,
	input wire logic [3:0] clock_source_fuse,
	input wire logic debug_enable_fuse,
	input wire logic converter_enable,
	input wire sleep_gate_pkg::clk_en_s clk_en,
	input wire logic [7:0] periph_reg_block,
	input wire logic cpu_halt,
	input wire logic conv_start,
	input wire logic comparator_mux_block
);
	logic [7:0] ctl;
	logic [7:0] gate_w;
	logic [1:0] since_wr;
	wire go = sleep_instr && ctl[0] && !cpu_halt;
	wire [2:0] md = ctl[3:1];
	wire xtal = clock_source_fuse >= 4'h8;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			ctl <= 8'h00;
			gate_w <= 8'h00;
			since_wr <= 2'h3;
		end else begin
			if (reg_wr && reg_addr == 4'h0) ctl <= reg_wdata;
			if (reg_wr && reg_addr == 4'h1) gate_w <= reg_wdata;
			// Copy may lag the write by up to three cycles
			if (reg_wr && reg_addr == 4'h1) since_wr <= 2'h0;
			else if (since_wr != 2'h3) since_wr <= since_wr + 2'h1;
		end
	end
	sequence halt4;
		(cpu_halt && !clk_en.cpu) [*4] ##1 (!cpu_halt && clk_en == 6'h3f);
	endsequence
	sequence restart6;
		(cpu_halt && clk_en == 6'h01) [*6];
	endsequence
	sleep_entry_a: assert property (go |=> cpu_halt)
		else $error("sleep not entered");
	idle_clocks_a: assert property (go && md inside {3'h0, 3'h3, 3'h4, 3'h5, 3'h7} |=> clk_en == 6'h0f)
		else $error("idle clock set wrong");
	noise_clocks_a: assert property (go && md == 3'h1 |=> clk_en == 6'h07)
		else $error("noise clock set wrong");
	conv_start_a: assert property (go && md == 3'h1 && converter_enable |=> conv_start ##1 !conv_start)
		else $error("no conversion pulse");
	pdown_clocks_a: assert property (go && (md == 3'h2 || (md == 3'h6 && !xtal)) |=> clk_en == {5'h00, debug_enable_fuse})
		else $error("power-down clock set wrong");
	standby_clocks_a: assert property (go && md == 3'h6 && xtal |=> clk_en == 6'h01)
		else $error("standby clock set wrong");
	idle_wake_a: assert property ($rose(wake_src.any_irq) && cpu_halt && clk_en == 6'h0f |=> halt4)
		else $error("idle wake halt wrong");
	standby_wake_a: assert property ($rose(wake_src.stage_ctrl) && cpu_halt && clk_en == 6'h01 && md == 3'h6 && xtal
		|=> restart6 ##1 halt4)
		else $error("standby wake timing wrong");
	gate_copy_a: assert property (since_wr == 2'h3 |-> periph_reg_block == gate_w)
		else $error("gate copy wrong");
	mux_block_a: assert property (since_wr == 2'h3 |-> comparator_mux_block == gate_w[0])
		else $error("mux block wrong");
endmodule : sleep_gate_assertions
bind sleep_and_module_clock_gating sleep_gate_assertions chk_u (.core_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr,
	.sleep_instr, .wake_src, .clock_source_fuse, .debug_enable_fuse, .converter_enable, .clk_en, .periph_reg_block,
	.cpu_halt, .conv_start, .comparator_mux_block);

/* dv/sleep_and_module_clock_gating_tb_top.sv */
// Directed bench for the sleep controller
`timescale 1ns/1ns
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin num_errors++; \
	$display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); end end
module sleep_and_module_clock_gating_tb_top;
	localparam int SH = 8;
	localparam int LG = 16;
	logic core_clk = 1'h0;
	logic resetn = 1'h0;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_wr = 1'h0;
	logic reg_rd = 1'h0;
	logic [7:0] reg_rdata;
	logic sleep_instr;
	logic sleep_req = 1'h0;
	sleep_gate_pkg::wake_src_s wake_src;
	sleep_gate_pkg::wake_src_s raise = '0;
	logic [3:0] external_interrupt_lines = 4'h0;
	logic [3:0] clock_source_fuse = 4'h8;
	logic debug_enable_fuse = 1'h0;
	logic converter_enable = 1'h1;
	logic comparator_enable = 1'h1;
	logic comparator_uses_ref = 1'h0;
	logic watchdog_enable = 1'h1;
	logic brownout_enable = 1'h1;
	sleep_gate_pkg::clk_en_s clk_en;
	logic [7:0] periph_clk_en;
	logic [7:0] periph_reg_block;
	logic cpu_halt, conv_start, conv_extended, conv_keep_enabled, comparator_off;
	logic comparator_mux_block, input_buf_disable, watchdog_run, brownout_run;
	int num_errors = 0;
	int compares = 0;
	always #25 core_clk = ~core_clk;
	sleep_and_module_clock_gating #(.PDOWN_WAKE_SHORT(SH), .PDOWN_WAKE_LONG(LG)) dut_u (.core_clk, .resetn,
		.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .sleep_instr, .wake_src, .external_interrupt_lines,
		.clock_source_fuse, .debug_enable_fuse, .converter_enable, .comparator_enable, .comparator_uses_ref,
		.watchdog_enable, .brownout_enable, .clk_en, .periph_clk_en, .periph_reg_block, .cpu_halt, .conv_start,
		.conv_extended, .conv_keep_enabled, .comparator_off, .comparator_mux_block, .input_buf_disable,
		.watchdog_run, .brownout_run);
	wake_source_model core_u (.core_clk, .resetn, .cpu_halt, .sleep_req, .raise, .sleep_instr, .wake_src);
	task wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'h1;
		@(posedge core_clk);
		reg_wr <= 1'h0;
	endtask : wr
	task rd(input logic [3:0] a, input logic [7:0] e);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge core_clk);
		reg_rd <= 1'h0;
		@(negedge core_clk);
		`CHK(reg_rdata, e)
	endtask : rd
	task nap(input logic [2:0] m, input sleep_gate_pkg::clk_en_s e);
		wr(4'h0, {4'h0, m, 1'h1});
		@(posedge core_clk) sleep_req <= 1'h1;
		@(posedge core_clk) sleep_req <= 1'h0;
		@(posedge core_clk);
		@(negedge core_clk);
		`CHK(cpu_halt, 1'h1)
		`CHK(clk_en, e)
	endtask : nap
	// Cycles counted from the edge that launches the wake request
	task wake(input sleep_gate_pkg::wake_src_s s, input logic [3:0] l, input int e);
		int n;
		n = 1;
		@(posedge core_clk);
		raise <= s;
		external_interrupt_lines <= l;
		@(posedge core_clk) raise <= '0;
		@(negedge core_clk);
		while (cpu_halt !== 1'h0 && n < 100) begin
			@(negedge core_clk);
			n++;
		end
		`CHK(n, e)
		@(posedge core_clk) external_interrupt_lines <= 4'h0;
	endtask : wake
	task summarize;
		$display("num_errors=%0d compares=%0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : summarize
	initial begin
		repeat (4) @(posedge core_clk);
		resetn <= 1'h1;
		repeat (3) @(posedge core_clk);
		rd(4'h0, 8'h00);
		rd(4'h1, 8'h00);
		`CHK(conv_extended, 1'h1)
		wr(4'h0, 8'hff);
		rd(4'h0, 8'h0f);
		wr(4'h0, 8'h00);
		wr(4'h5, 8'hff);
		rd(4'h5, 8'h00);
		@(posedge core_clk) sleep_req <= 1'h1;
		@(posedge core_clk) sleep_req <= 1'h0;
		repeat (2) @(negedge core_clk);
		`CHK(cpu_halt, 1'h0)
		@(posedge core_clk) converter_enable <= 1'h0;
		for (int i = 0; i < 8; i++) begin
			wr(4'h1, 8'h01 << i);
			repeat (2) @(negedge core_clk);
			`CHK(periph_clk_en, ~(8'h01 << i))
			`CHK(periph_reg_block, 8'h01 << i)
			`CHK(comparator_mux_block, i == 0)
		end
		`CHK(conv_keep_enabled, 1'h0)
		wr(4'h1, 8'h5a);
		@(posedge core_clk) converter_enable <= 1'h1;
		for (int m = 0; m < 8; m++) if (!(m inside {1, 2, 6})) begin
			nap(3'(m), 6'h0f);
			`CHK(periph_clk_en, 8'ha5)
			`CHK(input_buf_disable, 1'h0)
			wake(m == 7 ? 5'h00 : 5'h10, m == 7 ? 4'h1 : 4'h0, m == 7 ? 7 : 6);
		end
		for (int k = 1; k < 4; k++) begin
			nap(3'h1, 6'h07);
			`CHK(conv_keep_enabled, 1'h1)
			`CHK(input_buf_disable, 1'h0)
			wake(5'h10 >> k, 4'h0, 6);
			`CHK(conv_extended, 1'h0)
		end
		@(posedge core_clk) converter_enable <= 1'h0;
		@(posedge core_clk) converter_enable <= 1'h1;
		repeat (3) @(negedge core_clk);
		`CHK(conv_extended, 1'h1)
		nap(3'h2, 6'h00);
		`CHK(periph_clk_en, 8'h00)
		`CHK(comparator_off, 1'h1)
		`CHK(input_buf_disable, 1'h1)
		`CHK(watchdog_run, 1'h1)
		`CHK(brownout_run, 1'h1)
		rd(4'h2, 8'h24);
		@(posedge core_clk) raise <= 5'h04;
		@(posedge core_clk) raise <= '0;
		repeat (20) @(negedge core_clk);
		`CHK(cpu_halt, 1'h1)
		wake(5'h01, 4'h0, 2 + SH + 4);
		clock_source_fuse <= 4'h1;
		nap(3'h6, 6'h00);
		wake(5'h00, 4'h2, 3 + LG + 4);
		clock_source_fuse <= 4'h8;
		comparator_uses_ref <= 1'h1;
		nap(3'h6, 6'h01);
		`CHK(comparator_off, 1'h0)
		wake(5'h01, 4'h0, 12);
		debug_enable_fuse <= 1'h1;
		nap(3'h2, 6'h01);
		wake(5'h00, 4'h8, 3 + SH + 4);
		watchdog_enable <= 1'h0;
		brownout_enable <= 1'h0;
		wr(4'h1, 8'h00);
		repeat (2) @(negedge core_clk);
		`CHK(periph_clk_en, 8'hff)
		`CHK(watchdog_run, 1'h0)
		`CHK(brownout_run, 1'h0)
		summarize();
	end
	initial begin
		#300000;
		num_errors++;
		summarize();
	end
endmodule : sleep_and_module_clock_gating_tb_top
